// File: rtl/vic_regs.sv
// Interrupt controller register model with acknowledge arbitration
// What this block does
// - One pending bit per source, two words
// - Pending shows raw requests ignoring mask
// - Pending clears at reset, read-only, bit0 zero
// - Mask bits read/write, set at reset
// - Writing mask bit0 sets all mask bits
// - Force bits request, bypass mask, reset clear
// - Per-level request summary refreshed every cycle
// - Each acknowledge with a winner records level and priority
// - Control byte holds level and priority
// - Controls readable; only sources 8-63 writable
// - Level ack returns top source of level
// - Software ack returns top unmasked or forced source
// - Empty software ack returns zero, clears record
// - Acks arbitrate across all controller instances
// - Acknowledge cycle equals explicit ack read
// - 256-byte window, wide registers split hi/lo
// - Vector equals 64 plus source number
// - Acknowledged level from address bits 4:2
// - Empty level ack returns vector 24
// - Drive decoded 7-bit level request to core
`timescale 1ns/1ps
module vic_regs (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [3:0] reg_be,
    input wire logic [31:0] reg_wdata,
    input wire logic interrupt_acknowledge,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Request sources, bit 0 unused
    input wire logic [63:0] src_req,
    // Decoded level request to the core, bit 0 is level 1
    output logic [6:0] level_req,
    // Cascade with the other controller instances
    input wire logic peer_valid,
    input wire logic [6:0] peer_rank,
    input wire logic [7:0] peer_vector,
    output logic cand_valid,
    output logic [6:0] cand_rank,
    output logic [7:0] cand_vector
);
    vic_pkg::vic_state_s st;
    vic_pkg::vic_state_s next_st;
    logic [63:0] active;
    logic [63:0] elig;
    vic_pkg::vic_rank_s [63:0] rank;
    logic ack_hit;
    logic sw_ack;
    logic [2:0] ack_lvl;
    logic loc_found;
    logic [5:0] loc_idx;
    vic_pkg::vic_rank_s loc_rank;
    logic use_peer;
    logic win_found;
    logic [7:0] win_vector;
    vic_pkg::vic_rank_s win_rank;

    // Source zero does not exist
    assign active[0] = 1'b0;
    assign elig[0] = 1'b0;
    assign rank[0] = '0;

    genvar g;
    generate
        for (g = 1; g < vic_pkg::NUM_SRC; g++)
        begin : g_src
            vic_src_slot #(
                .IDX(6'(g))
            ) u_slot (
                .hw_req(src_req[g]),
                .force_bit(st.forced[g]),
                .mask_bit(st.mask[g]),
                .ctrl(st.ctrl[g]),
                .active(active[g]),
                .eligible(elig[g]),
                .rank(rank[g])
            );
        end
    endgenerate

    // Ack cycles and explicit ack reads share one decode
    assign ack_hit = reg_rd
        && (interrupt_acknowledge || reg_addr[7:5] == vic_pkg::ACK_REGION);
    assign ack_lvl = reg_addr[4:2];
    assign sw_ack = ack_lvl == vic_pkg::SW_ACK_LVL;

    vic_pick u_pick (
        .elig(elig),
        .rank(rank),
        .lvl_only(!sw_ack),
        .lvl(ack_lvl),
        .found(loc_found),
        .idx(loc_idx),
        .best(loc_rank)
    );

    // Peer candidates answer the same address, so the best overall wins
    assign cand_valid = loc_found;
    assign cand_rank = loc_rank;
    assign cand_vector = vic_pkg::VEC_BASE + {2'h0, loc_idx};
    assign use_peer = peer_valid
        && (!loc_found || peer_rank > loc_rank);
    assign win_found = loc_found || peer_valid;
    assign win_vector = use_peer ? peer_vector : cand_vector;
    assign win_rank = use_peer ? vic_pkg::vic_rank_s'(peer_rank) : loc_rank;

    always_comb
    begin
        logic [5:0] sidx;
        logic [63:0] vis_mask;
        logic [63:0] vis_frc;
        sidx = 6'h0;
        vis_mask = st.mask;
        vis_frc = st.forced;
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.pending = active;
        next_st.summary = 8'h0;
        // Summary reflects requests that could interrupt right now
        for (int i = 1; i < vic_pkg::NUM_SRC; i++)
        begin
            if (elig[i])
            begin
                next_st.summary[rank[i].lvl] = 1'b1;
            end
        end
        // Writes, byte lane by byte lane
        if (reg_wr)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (reg_be[b])
                begin
                    unique case (reg_addr)
                        vic_pkg::OFF_MASK_HI:
                            next_st.mask[vic_pkg::HI_LSB + 8*b +: 8] =
                                reg_wdata[8*b +: 8];
                        vic_pkg::OFF_MASK_LO:
                            next_st.mask[8*b +: 8] = reg_wdata[8*b +: 8];
                        vic_pkg::OFF_FRC_HI:
                            next_st.forced[vic_pkg::HI_LSB + 8*b +: 8] =
                                reg_wdata[8*b +: 8];
                        vic_pkg::OFF_FRC_LO:
                            next_st.forced[8*b +: 8] = reg_wdata[8*b +: 8];
                        default:
                        begin
                            if (reg_addr[7:6] == vic_pkg::CTRL_REGION)
                            begin
                                sidx = {reg_addr[5:2], 2'(b)};
                                // Fixed sources ignore writes
                                if (sidx >= vic_pkg::CTRL_WR_FIRST)
                                begin
                                    next_st.ctrl[sidx] =
                                        reg_wdata[8*b +: 6];
                                end
                            end
                        end
                    endcase
                end
            end
            if (reg_addr == vic_pkg::OFF_MASK_LO && reg_be[0]
                && reg_wdata[vic_pkg::MASK_ALL_BIT])
            begin
                next_st.mask = vic_pkg::MASK_RST;
            end
            next_st.forced[0] = 1'b0;
        end
        // Reads, one cycle latency
        if (reg_rd)
        begin
            next_st.rvalid = 1'b1;
            next_st.rdata = 32'h0;
            if (ack_hit)
            begin
                if (win_found)
                begin
                    next_st.rdata[7:0] = win_vector;
                    next_st.record = {1'b0, win_rank};
                end
                else if (sw_ack)
                begin
                    next_st.rdata[7:0] = vic_pkg::VEC_NONE;
                    next_st.record = 8'h0;
                end
                else
                begin
                    next_st.rdata[7:0] = vic_pkg::VEC_SPURIOUS;
                end
            end
            else
            begin
                unique case (reg_addr)
                    vic_pkg::OFF_PEND_HI:
                        next_st.rdata = st.pending[63:32];
                    vic_pkg::OFF_PEND_LO:
                        next_st.rdata = st.pending[31:0];
                    vic_pkg::OFF_MASK_HI:
                        next_st.rdata = vis_mask[63:32];
                    vic_pkg::OFF_MASK_LO:
                        next_st.rdata = vis_mask[31:0];
                    vic_pkg::OFF_FRC_HI:
                        next_st.rdata = vis_frc[63:32];
                    vic_pkg::OFF_FRC_LO:
                        next_st.rdata = vis_frc[31:0];
                    vic_pkg::OFF_LVL_SUM:
                    begin
                        next_st.rdata[7:0] = st.summary;
                        next_st.rdata[vic_pkg::REC_LSB +: 8] = st.record;
                    end
                    default:
                    begin
                        // Unmapped words read zero
                        if (reg_addr[7:6] == vic_pkg::CTRL_REGION)
                        begin
                            for (int b = 0; b < 4; b++)
                            begin
                                sidx = {reg_addr[5:2], 2'(b)};
                                next_st.rdata[8*b +: 8] =
                                    {2'h0, st.ctrl[sidx]};
                                if (sidx != 6'h0
                                    && sidx <= vic_pkg::FIXED_LAST)
                                begin
                                    next_st.rdata[8*b +: 8] =
                                        {2'h0, sidx[2:0], 3'h0};
                                end
                            end
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st <= '0;
            st.mask <= vic_pkg::MASK_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    // Disabled levels and masked, unforced requests never reach the core
    assign level_req = st.summary[7:1];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    pend_zero_a: assert property (st.pending[0] == 1'b0 && !elig[0])
        else $error("pending bit zero set");
    pend_follow_a: assert property (
        1'b1 |=> st.pending == $past(active))
        else $error("pending does not follow raw requests");
    mask_reset_a: assert property (disable iff (1'b0)
        rst |=> st.mask == vic_pkg::MASK_RST && st.forced == 64'h0)
        else $error("mask or force wrong after reset");
    mask_all_a: assert property (
        reg_wr && reg_addr == vic_pkg::OFF_MASK_LO && reg_be[0]
        && reg_wdata[0] |=> st.mask == vic_pkg::MASK_RST)
        else $error("mask-all write did not set all bits");
    fixed_ctrl_a: assert property (
        reg_wr && reg_addr == {vic_pkg::CTRL_REGION, 6'h4}
        |=> $stable(st.ctrl[7:4]))
        else $error("fixed source control changed");
    lvl_spur_a: assert property (
        ack_hit && !sw_ack && !win_found
        |=> reg_rvalid && reg_rdata == 32'(vic_pkg::VEC_SPURIOUS))
        else $error("empty level ack not spurious");
    sw_empty_a: assert property (
        ack_hit && sw_ack && !win_found
        |=> reg_rdata == 32'h0 && st.record == 8'h0)
        else $error("empty software ack not zero");
    vec_map_a: assert property (
        ack_hit && loc_found && !peer_valid
        |=> reg_rdata[7:0] == vic_pkg::VEC_BASE + {2'h0, $past(loc_idx)})
        else $error("vector not 64 plus source");
    ack_rec_a: assert property (
        ack_hit && win_found
        |=> st.record == {1'b0, $past(win_rank)} ##1 $stable(st.record)
            || $past(ack_hit))
        else $error("ack record not loaded");
    lvl_only_a: assert property (
        ack_hit && !sw_ack && loc_found |-> loc_rank.lvl == ack_lvl)
        else $error("level ack winner from wrong level");
    forced_win_a: assert property (
        st.forced[9] && st.ctrl[9].lvl != 3'h0 |-> elig[9])
        else $error("forced source blocked by mask");

    sw_ack_c: cover property (ack_hit && sw_ack && win_found);
    spur_c: cover property (ack_hit && !sw_ack && !win_found);
    peer_win_c: cover property (ack_hit && use_peer && loc_found);
    mask_all_c: cover property (reg_wr && reg_addr == vic_pkg::OFF_MASK_LO
        && reg_wdata[0] ##1 st.mask == vic_pkg::MASK_RST);
endmodule // vic_regs

// File: rtl/vic_pkg.sv
// Constants, offsets and state types of the vectored interrupt controller
package vic_pkg;

    localparam int NUM_SRC = 64;

    // Word offsets of the register window
    localparam logic [7:0] OFF_PEND_HI = 8'h00;
    localparam logic [7:0] OFF_PEND_LO = 8'h04;
    localparam logic [7:0] OFF_MASK_HI = 8'h08;
    localparam logic [7:0] OFF_MASK_LO = 8'h0c;
    localparam logic [7:0] OFF_FRC_HI = 8'h10;
    localparam logic [7:0] OFF_FRC_LO = 8'h14;
    localparam logic [7:0] OFF_LVL_SUM = 8'h18;
    // Source control bytes live at 8'h40 + source, acks at 8'he0 + 4*level
    localparam logic [1:0] CTRL_REGION = 2'h1;
    localparam logic [2:0] ACK_REGION = 3'h7;
    localparam logic [2:0] SW_ACK_LVL = 3'h0;

    // Field placement inside words
    localparam int HI_LSB = 32;
    localparam int REC_LSB = 8;
    localparam int MASK_ALL_BIT = 0;

    // Reset values
    localparam logic [63:0] MASK_RST = 64'hffff_ffff_ffff_ffff;
    localparam logic [63:0] FORCE_RST = 64'h0;

    // Vectors
    localparam logic [7:0] VEC_BASE = 8'h40;
    localparam logic [7:0] VEC_SPURIOUS = 8'h18;
    localparam logic [7:0] VEC_NONE = 8'h00;

    // Fixed sources and priority layout inside a level
    localparam logic [5:0] FIXED_LAST = 6'h07;
    localparam logic [5:0] CTRL_WR_FIRST = 6'h08;
    localparam logic [3:0] FIXED_SUB = 4'h4;
    localparam logic [2:0] PRIO_SPLIT = 3'h4;
    localparam logic [2:0] LVL_OFF = 3'h0;

    typedef struct packed {
        logic [2:0] lvl;
        logic [2:0] prio;
    } vic_ctrl_s;

    typedef struct packed {
        logic [2:0] lvl;
        logic [3:0] sub;
    } vic_rank_s;

    typedef struct packed {
        logic [63:0] mask;
        logic [63:0] forced;
        vic_ctrl_s [63:0] ctrl;
        logic [63:0] pending;
        logic [7:0] summary;
        logic [7:0] record;
        logic [31:0] rdata;
        logic rvalid;
    } vic_state_s;

endpackage

// File: rtl/vic_src_slot.sv
// One request source: activity, eligibility and arbitration rank
`timescale 1ns/1ps
module vic_src_slot #(
    parameter logic [5:0] IDX = 6'h01
) (
    // Source inputs
    input wire logic hw_req,
    input wire logic force_bit,
    input wire logic mask_bit,
    input wire vic_pkg::vic_ctrl_s ctrl,
    // Results
    output logic active,
    output logic eligible,
    output vic_pkg::vic_rank_s rank
);
    logic fixed;
    logic [3:0] prog_sub;

    assign fixed = IDX <= vic_pkg::FIXED_LAST;
    // Programmable priorities sit either side of the fixed midpoint
    assign prog_sub = (ctrl.prio >= vic_pkg::PRIO_SPLIT)
        ? {1'b0, ctrl.prio} + 4'h1 : {1'b0, ctrl.prio};
    assign rank.lvl = fixed ? IDX[2:0] : ctrl.lvl;
    assign rank.sub = fixed ? vic_pkg::FIXED_SUB : prog_sub;
    assign active = hw_req | force_bit;
    // Level zero means never programmed, so never eligible
    assign eligible = (rank.lvl != vic_pkg::LVL_OFF)
        && ((hw_req && !mask_bit) || force_bit);
endmodule // vic_src_slot

// File: rtl/vic_pick.sv
// Highest-rank search over all sources, optionally within one level
`timescale 1ns/1ps
module vic_pick (
    // Candidates
    input wire logic [63:0] elig,
    input wire vic_pkg::vic_rank_s [63:0] rank,
    // Level filter
    input wire logic lvl_only,
    input wire logic [2:0] lvl,
    // Winner
    output logic found,
    output logic [5:0] idx,
    output vic_pkg::vic_rank_s best
);
    always_comb
    begin
        found = 1'b0;
        idx = 6'h0;
        best = '0;
        // Equal ranks are illegal; lowest index wins if it happens anyway
        for (int i = 1; i < vic_pkg::NUM_SRC; i++)
        begin
            if (elig[i] && (!lvl_only || rank[i].lvl == lvl)
                && (!found || rank[i] > best))
            begin
                found = 1'b1;
                idx = 6'(i);
                best = rank[i];
            end
        end
    end
endmodule // vic_pick

// File: bench/vic_core_model.sv
// Processor core model issuing register accesses and acknowledge cycles
`timescale 1ns/1ps
module vic_core_model (
    // Clock
    input wire logic core_clk,
    // Register port towards the controller
    output logic [7:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [3:0] reg_be,
    output logic [31:0] reg_wdata,
    output logic interrupt_acknowledge,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial
    begin
        reg_addr = 8'h0;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_be = 4'h0;
        reg_wdata = 32'h0;
        interrupt_acknowledge = 1'b0;
    end

    // Launch at the falling edge so the rising edge takes a settled request
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [3:0] e = 4'hf);
        @(negedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_be <= e;
        reg_wr <= 1'b1;
        @(negedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask

    // Answer stands one cycle only, so a late answer reads as unknown
    task automatic rd(input logic [7:0] a, input logic ia,
                      output logic [31:0] d);
        @(negedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        interrupt_acknowledge <= ia;
        @(negedge core_clk);
        reg_rd <= 1'b0;
        interrupt_acknowledge <= 1'b0;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hx;
    endtask
endmodule // vic_core_model

// File: bench/tb.sv
// Self-checking bench of the interrupt controller registers
`timescale 1ns/1ps
module tb;
    logic core_clk, rst, reg_rd, reg_wr, interrupt_acknowledge, reg_rvalid;
    logic peer_valid, cand_valid;
    logic [7:0] reg_addr, peer_vector, cand_vector, rec, v;
    logic [3:0] reg_be;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [63:0] src_req, msk, frc, pnd;
    logic [6:0] level_req, peer_rank, cand_rank, win_rank;
    logic [5:0] ctl [64];
    int fail_count, checked, seed, k;

    vic_regs vic_regs_inst (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_be(reg_be), .reg_wdata(reg_wdata), .interrupt_acknowledge(interrupt_acknowledge),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .src_req(src_req),
        .level_req(level_req), .peer_valid(peer_valid),
        .peer_rank(peer_rank), .peer_vector(peer_vector),
        .cand_valid(cand_valid), .cand_rank(cand_rank),
        .cand_vector(cand_vector));
    vic_core_model vic_core_model_inst (.core_clk(core_clk),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_be(reg_be), .reg_wdata(reg_wdata), .interrupt_acknowledge(interrupt_acknowledge),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    function automatic logic [6:0] rank_of(int s);
        logic [3:0] p;
        p = {1'b0, ctl[s][2:0]};
        if (s < 8)
            return {3'(s), 4'h4};
        return {ctl[s][5:3], (p < 4'h4) ? p : p + 4'h1};
    endfunction

    function automatic logic elig(int s);
        logic [6:0] r;
        r = rank_of(s);
        return s != 0 && r[6:4] != 3'h0
            && ((src_req[s] && !msk[s]) || frc[s]);
    endfunction

    // Winner of one level, or of all levels when l is zero
    function automatic logic [7:0] pick(logic [2:0] l);
        logic [7:0] w;
        logic [6:0] r;
        w = 8'h0;
        for (int s = 1; s < 64; s++)
        begin
            r = rank_of(s);
            if (elig(s) && (l == 3'h0 || r[6:4] == l)
                && (w == 8'h0 || r > win_rank))
            begin
                win_rank = r;
                w = 8'h40 + 8'(s);
            end
        end
        return w;
    endfunction

    function automatic logic [7:0] sum_exp();
        logic [7:0] m;
        logic [6:0] r;
        m = 8'h0;
        for (int s = 1; s < 64; s++)
        begin
            r = rank_of(s);
            if (elig(s))
                m[r[6:4]] = 1'b1;
        end
        return m;
    endfunction

    task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic ia = 1'b0);
        vic_core_model_inst.rd(a, ia, d);
    endtask

    task automatic check_all();
        pnd = (src_req | frc) & ~64'h1;
        rd(8'h00);
        cmp(d, pnd[63:32], "pending hi");
        rd(8'h04);
        cmp(d, pnd[31:0], "pending lo");
        rd(8'h08);
        cmp(d, msk[63:32], "mask hi");
        rd(8'h0c);
        cmp(d, msk[31:0], "mask lo");
        rd(8'h10);
        cmp(d, frc[63:32], "force hi");
        rd(8'h14);
        cmp(d, frc[31:0], "force lo");
        rd(8'h18);
        cmp({24'h0, d[7:0]}, {24'h0, sum_exp()}, "summary");
        cmp({25'h0, level_req}, {24'h0, sum_exp() >> 1}, "lvl");
        for (int l = 0; l < 8; l++)
        begin
            v = pick(3'(l));
            // Odd levels arrive as acknowledge cycles with junk upper bits
            if (l[0])
                rd({3'($random(seed)), 3'(l), 2'h0}, 1'b1);
            else
                rd(8'he0 + 8'(4 * l));
            if (l == 0)
                cmp({31'h0, cand_valid}, {31'h0, v != 8'h0}, "cand");
            if (l == 0 && v != 8'h0)
                cmp({17'h0, cand_rank, cand_vector}, {17'h0, win_rank, v},
                    "cand rank");
            if (v != 8'h0)
                rec = {1'b0, win_rank};
            else if (l == 0)
                rec = 8'h0;
            if (l != 0 && v == 8'h0)
                v = 8'h18;
            cmp({24'h0, d[7:0]}, {24'h0, v},
                "vector");
            rd(8'h18);
            cmp({24'h0, d[15:8]}, {24'h0, rec}, "record");
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Bounded run time; a hang counts as a mismatch
    initial
    begin
        #400000;
        fail_count++;
        print_verdict();
    end

    initial
    begin
        seed = 32'hf85d3510;
        fail_count = 0;
        checked = 0;
        rst = 1'b1;
        src_req = 64'h0;
        peer_valid = 1'b0;
        peer_rank = 7'h0;
        peer_vector = 8'h0;
        msk = '1;
        frc = 64'h0;
        rec = 8'h0;
        for (int s = 0; s < 64; s++)
            ctl[s] = (s > 0 && s < 8) ? {3'(s), 3'h0} : 6'h0;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        // Read-only, ack, unmapped and fixed control words ignore writes
        foreach (ctl[i])
            if (i < 8)
                vic_core_model_inst.wr(8'(4 * i) + ((i < 2) ? 8'h40 :
                    8'he0), '1);
        vic_core_model_inst.wr(8'h00, '1);
        vic_core_model_inst.wr(8'h18, '1);
        vic_core_model_inst.wr(8'h30, '1);
        rd(8'h30);
        cmp(d, 32'h0, "unmapped");
        check_all();
        $display("test reset done");
        src_req = {$random(seed), $random(seed)};
        vic_core_model_inst.wr(8'h08, 32'h0);
        vic_core_model_inst.wr(8'h0c, 32'h0);
        msk = 64'h0;
        check_all();
        vic_core_model_inst.wr(8'h0c, 32'h1);
        msk = '1;
        check_all();
        $display("test mask all done");
        // Rotated pairs give every source a unique level and priority
        k = {$random(seed)} % 56;
        for (int s = 8; s < 64; s++)
            ctl[s] = 6'(8 + (s + k) % 56);
        for (int w = 2; w < 16; w++)
            vic_core_model_inst.wr(8'h40 + 8'(4 * w), {2'h0, ctl[4 * w + 3],
                2'h0, ctl[4 * w + 2], 2'h0, ctl[4 * w + 1],
                2'h0, ctl[4 * w]});
        for (int w = 0; w < 16; w++)
        begin
            rd(8'h40 + 8'(4 * w));
            cmp(d & ((w == 0) ? 32'hffffff00 : '1), {2'h0, ctl[4 * w + 3],
                2'h0, ctl[4 * w + 2], 2'h0, ctl[4 * w + 1], 2'h0,
                (w == 0) ? 6'h0 : ctl[4 * w]}, "control");
        end
        $display("test control done");
        repeat (30)
        begin
            src_req = {$random(seed), $random(seed)};
            frc = {$random(seed), $random(seed)} & {$random(seed),
                $random(seed)} & {$random(seed), $random(seed)};
            msk = {$random(seed), $random(seed)};
            msk[0] = ($random(seed) & 3) == 0;
            vic_core_model_inst.wr(8'h10, frc[63:32]);
            vic_core_model_inst.wr(8'h14, frc[31:0]);
            frc[0] = 1'b0;
            // No acknowledge is in flight while masks change
            vic_core_model_inst.wr(8'h08, msk[63:32]);
            vic_core_model_inst.wr(8'h0c, msk[31:0]);
            if (msk[0])
                msk = '1;
            check_all();
        end
        $display("test random done");
        peer_valid = 1'b1;
        peer_rank = 7'h7f;
        peer_vector = 8'h55;
        rd(8'he0);
        cmp({24'h0, d[7:0]}, 32'h55, "peer wins");
        peer_valid = 1'b0;
        $display("test cascade done");
        // Mid-run reset, then byte-lane force writes
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        msk = '1;
        rec = 8'h0;
        for (int s = 8; s < 64; s++)
            ctl[s] = 6'h0;
        frc = {8'ha5, 40'h0, 8'hff, 8'h0};
        vic_core_model_inst.wr(8'h10, 32'ha5ff_ffff, 4'h8);
        vic_core_model_inst.wr(8'h14, 32'hffff_ffff, 4'h2);
        check_all();
        $display("test mid reset done");
        print_verdict();
    end
endmodule // tb
